// ===== logic/asrp_pkg.sv
// Purpose: constants for the host-side controller of a 4K x 1 asynchronous static memory
// Assumes: CLOCK at 10 MHz; one memory cycle per request
// Notes:   timing counts derive from the printed ns figures and the clock period
package asrp_pkg;
	// ----------------------------------------------------------------
	// geometry and timing
	// ----------------------------------------------------------------
	localparam int          ASRP_ADDR_W       = 12;   // twelve location bits, 4K cells
	localparam int          ASRP_CLK_PERIOD_NS = 100; // clock period
	localparam int          ASRP_T_ACCESS_NS  = 45;   // slowest access time
	localparam int          ASRP_T_CW_NS      = 40;   // select to end of write, slowest grade
	localparam int          ASRP_T_AW_NS      = 40;   // address setup to end of write
	localparam int          ASRP_T_DW_NS      = 20;   // data setup to end of write
	localparam int          ASRP_T_HZ_NS      = 20;   // output float time, slowest grade
	localparam int          ASRP_T_PD_NS      = 30;   // power down after deselect
	// least times round up to whole cycles, at least one
	localparam int          ASRP_ACC_CYC  = (ASRP_T_ACCESS_NS + ASRP_CLK_PERIOD_NS - 1) / ASRP_CLK_PERIOD_NS;
	localparam int          ASRP_WR_NS    = (ASRP_T_CW_NS > ASRP_T_AW_NS) ? ASRP_T_CW_NS : ASRP_T_AW_NS;
	localparam int          ASRP_WR_CYC   = (ASRP_WR_NS + ASRP_CLK_PERIOD_NS - 1) / ASRP_CLK_PERIOD_NS;
	localparam int          ASRP_HZ_CYC   = (ASRP_T_HZ_NS + ASRP_CLK_PERIOD_NS - 1) / ASRP_CLK_PERIOD_NS;
	localparam int          ASRP_CNT_W    = 4;
	localparam logic [3:0]  ASRP_CNT_ZERO = 4'h0;

	// controller states
	typedef enum logic [2:0] {
		ASRP_IDLE,
		ASRP_RD_WAIT,
		ASRP_WR_SETUP,
		ASRP_WR_PULSE,
		ASRP_RECOVER
	} asrp_state_e;
endpackage : asrp_pkg

// ===== logic/asrp_pins_if.sv
// Purpose: memory pin bundle between the sequencer and the pin register stage
// Assumes: single clock domain
// Notes:   strobes are active low
interface asrp_pins_if;
	import asrp_pkg::*;
	logic [ASRP_ADDR_W-1:0] location_bits; // address to memory
	logic                   chip_on_n;     // select strobe
	logic                   store_n;       // write strobe
	logic                   in_bit;        // write data
	modport seq (output location_bits, chip_on_n, store_n, in_bit);
	modport pin (input  location_bits, chip_on_n, store_n, in_bit);
endinterface : asrp_pins_if

// ===== logic/asrp_pin_reg.sv
// Purpose: registers memory pins so they leave flip-flops glitch-free
// Assumes: synchronous active-high reset
// Notes:   reset parks the memory deselected
module asrp_pin_reg
	import asrp_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// next pin values
	asrp_pins_if.pin                    nxt,
	// memory pins
	output logic     [ASRP_ADDR_W-1:0]  location_bits,
	output logic                        chip_on_n,
	output logic                        store_n,
	output logic                        in_bit
);
	// ----------------------------------------------------------------
	// pin flops
	// ----------------------------------------------------------------
	// strobes, reset high so the memory is deselected and never written
	always_ff @(posedge clk) begin
		if (rst) begin
			chip_on_n <= 1'b1;
			store_n   <= 1'b1;
		end else begin
			chip_on_n <= nxt.chip_on_n;
			store_n   <= nxt.store_n;
		end
	end

	// address and data
	always_ff @(posedge clk) begin
		if (rst) begin
			location_bits <= '0;
			in_bit        <= 1'b0;
		end else begin
			location_bits <= nxt.location_bits;
			in_bit        <= nxt.in_bit;
		end
	end
endmodule : asrp_pin_reg

// ===== logic/asrp_ctrl.sv
// Purpose: host controller driving a 4K x 1 asynchronous static memory
// Assumes: out_bit is synchronous to CLOCK (wire settles well inside 100 ns)
// Notes:   one request at a time; REQ_READY high only in idle
module asrp_ctrl
	import asrp_pkg::*;
(
	// clock and reset
	input  wire logic                         CLOCK,
	input  wire logic                         RST,
	// user request
	input  wire logic                         REQ_VALID,
	input  wire logic                         REQ_WRITE,
	input  wire logic [asrp_pkg::ASRP_ADDR_W-1:0] REQ_ADDR,
	input  wire logic                         REQ_DATA,
	output logic                              REQ_READY,
	// user answer
	output logic                              RSP_VALID,
	output logic                              RSP_DATA,
	// memory pins
	output logic [asrp_pkg::ASRP_ADDR_W-1:0]  LOCATION_BITS,
	output logic                              CHIP_ON_N,
	output logic                              STORE_N,
	output logic                              IN_BIT,
	input  wire logic                         OUT_BIT
);
	import asrp_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	asrp_state_e               state;       // sequencer state
	asrp_state_e               next_state;  // next sequencer state
	logic [ASRP_CNT_W-1:0]     count;       // phase timer
	logic [ASRP_CNT_W-1:0]     next_count;  // next timer value
	logic [ASRP_ADDR_W-1:0]    addr;        // held address
	logic                      wdata;       // held write data
	logic                      is_write;    // held direction
	asrp_pins_if               pins ();     // next pin values

	// cycles as timer load value (count down to zero)
	function automatic logic [ASRP_CNT_W-1:0] cyc_load(input int cyc);
		cyc_load = ASRP_CNT_W'(cyc - 1);
	endfunction : cyc_load

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_count = (count == ASRP_CNT_ZERO) ? count : count - 1'b1;
		case (state)
			// accept a request
			ASRP_IDLE: begin
				if (REQ_VALID) begin
					// write starts when store_n falls last
					next_state = REQ_WRITE ? ASRP_WR_SETUP : ASRP_RD_WAIT;
					next_count = cyc_load(ASRP_ACC_CYC);
				end
			end
			// wait address or enable access time
			ASRP_RD_WAIT: begin
				if (count == ASRP_CNT_ZERO) begin
					next_state = ASRP_RECOVER;
					next_count = cyc_load(ASRP_HZ_CYC);
				end
			end
			// one cycle selected with store_n high, address settled
			ASRP_WR_SETUP: begin
				next_state = ASRP_WR_PULSE;
				next_count = cyc_load(ASRP_WR_CYC);
			end
			ASRP_WR_PULSE: begin
				if (count == ASRP_CNT_ZERO) begin
					next_state = ASRP_RECOVER;
					next_count = cyc_load(ASRP_HZ_CYC);
				end
			end
			ASRP_RECOVER: begin
				if (count == ASRP_CNT_ZERO) begin
					next_state = ASRP_IDLE;
				end
			end
			default: begin
				next_state = ASRP_IDLE;
			end
		endcase
	end

	// state and timer
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state <= ASRP_IDLE;
			count <= ASRP_CNT_ZERO;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// capture request so address stays fixed across the cycle
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			addr     <= '0;
			wdata    <= 1'b0;
			is_write <= 1'b0;
		end else if (state == ASRP_IDLE && REQ_VALID) begin
			addr     <= REQ_ADDR;
			wdata    <= REQ_DATA;
			is_write <= REQ_WRITE;
		end
	end

	// ----------------------------------------------------------------
	// pin values
	// ----------------------------------------------------------------
	// select in any active phase
	assign pins.chip_on_n     = !(next_state == ASRP_RD_WAIT || next_state == ASRP_WR_SETUP ||
	                             next_state == ASRP_WR_PULSE);
	// store_n low only in the write pulse, high for reads
	assign pins.store_n       = !(next_state == ASRP_WR_PULSE);
	// address presented with the select, before the pulse
	assign pins.location_bits = (state == ASRP_IDLE) ? REQ_ADDR : addr;
	// data set up with the address, held through the strobe rise
	assign pins.in_bit        = (state == ASRP_IDLE) ? REQ_DATA : wdata;

	// both strobes rise together, ending the write
	asrp_pin_reg u_pins (
		.clk           (CLOCK),
		.rst           (RST),
		.nxt           (pins),
		.location_bits (LOCATION_BITS),
		.chip_on_n     (CHIP_ON_N),
		.store_n       (STORE_N),
		.in_bit        (IN_BIT)
	);

	// ----------------------------------------------------------------
	// answer
	// ----------------------------------------------------------------
	assign REQ_READY = (state == ASRP_IDLE);

	// sample out_bit at the end of access while still selected
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			RSP_VALID <= 1'b0;
			RSP_DATA  <= 1'b0;
		end else begin
			RSP_VALID <= 1'b0;
			if (state == ASRP_RD_WAIT && count == ASRP_CNT_ZERO) begin
				RSP_VALID <= 1'b1;
				RSP_DATA  <= OUT_BIT;
			end else if (state == ASRP_WR_PULSE && count == ASRP_CNT_ZERO) begin
				RSP_VALID <= 1'b1;
			end
		end
	end
endmodule : asrp_ctrl

// ===== verif/asrp_sram_model.sv
// Purpose: 4K x 1 memory seen from its pins
// Assumes: pins come from flops
// Notes:   a floating output shows the inverse of the last data
module asrp_sram_model
	import asrp_pkg::*;
#(parameter int ACC_NS = ASRP_T_ACCESS_NS)
(
	// memory pins
	input  wire logic [ASRP_ADDR_W-1:0] LOCATION_BITS,
	input  wire logic                   CHIP_ON_N,
	input  wire logic                   STORE_N,
	input  wire logic                   IN_BIT,
	output wire logic                   OUT_BIT
);
	timeunit 1ns;
	timeprecision 1ns;
	logic mem [2**ASRP_ADDR_W];
	logic last = 1'h0;
	wire  rd = !CHIP_ON_N && STORE_N;
	wire  wr = !CHIP_ON_N && !STORE_N;
	always @(negedge wr) mem[LOCATION_BITS] = IN_BIT;
	always @* if (rd) last = mem[LOCATION_BITS];
	// deselected means standby: no read, stale inverse shown
	assign #(ACC_NS) OUT_BIT = rd ? last : ~last;
endmodule : asrp_sram_model

// ===== verif/asrp_sva.sv
// Purpose: pin sequence checks for the controller
// Assumes: one clock domain
// Notes:   bound to asrp_ctrl
module asrp_sva
	import asrp_pkg::*;
(
	input wire logic CLOCK, RST, REQ_VALID, REQ_WRITE, REQ_DATA, REQ_READY,
	input wire logic RSP_VALID, RSP_DATA, CHIP_ON_N, STORE_N, IN_BIT, OUT_BIT,
	input wire logic [asrp_pkg::ASRP_ADDR_W-1:0] REQ_ADDR, LOCATION_BITS
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	wire rd = REQ_VALID && REQ_READY && !REQ_WRITE;
	wire wr = REQ_VALID && REQ_READY && REQ_WRITE;
	sequence s_pulse; !CHIP_ON_N && !STORE_N; endsequence
	sequence s_end; CHIP_ON_N && STORE_N && RSP_VALID; endsequence
	property p_rd_sel; rd |=> !CHIP_ON_N && STORE_N && LOCATION_BITS == $past(REQ_ADDR); endproperty
	a_rd_sel: assert property (p_rd_sel) else $error("read select");
	property p_rd_data; rd |=> ##1 CHIP_ON_N && RSP_VALID && RSP_DATA == $past(OUT_BIT); endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data");
	property p_wr; wr |=> (!CHIP_ON_N && STORE_N && IN_BIT == $past(REQ_DATA)) ##1 s_pulse ##1 s_end; endproperty
	a_wr: assert property (p_wr) else $error("write order");
	property p_store; !STORE_N |-> !CHIP_ON_N; endproperty
	a_store: assert property (p_store) else $error("store unselected");
	property p_hold; !CHIP_ON_N && !$past(CHIP_ON_N) |-> $stable(LOCATION_BITS) && $stable(IN_BIT); endproperty
	a_hold: assert property (p_hold) else $error("pins moved");
	property p_sel; $fell(CHIP_ON_N) |-> STORE_N; endproperty
	a_sel: assert property (p_sel) else $error("select with store");
	property p_rsp; RSP_VALID |-> !REQ_READY ##1 REQ_READY; endproperty
	a_rsp: assert property (p_rsp) else $error("ready order");
	property p_idle; REQ_READY |-> CHIP_ON_N && STORE_N; endproperty
	a_idle: assert property (p_idle) else $error("idle selected");
endmodule : asrp_sva
bind asrp_ctrl asrp_sva asrp_sva_inst (.CLOCK, .RST, .REQ_VALID, .REQ_WRITE, .REQ_DATA, .REQ_READY, .RSP_VALID,
	.RSP_DATA, .CHIP_ON_N, .STORE_N, .IN_BIT, .OUT_BIT, .REQ_ADDR, .LOCATION_BITS);

// ===== verif/asrp_ctrl_tb_top.sv
// Purpose: bench for asrp_ctrl with a memory model
// Assumes: inputs change 1 ns after the rising edge
// Notes:   latency counted from the take edge
module asrp_ctrl_tb_top;
	import asrp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   CLOCK = 0, RST = 1, REQ_VALID = 0, REQ_WRITE = 0, REQ_DATA = 0;
	logic [ASRP_ADDR_W-1:0] REQ_ADDR = '0, LOCATION_BITS;
	logic                   REQ_READY, RSP_VALID, RSP_DATA, CHIP_ON_N, STORE_N, IN_BIT, OUT_BIT;
	int                     n_errors = 0, checks_done = 0;
	asrp_ctrl asrp_ctrl_inst (.CLOCK, .RST, .REQ_VALID, .REQ_WRITE, .REQ_ADDR, .REQ_DATA, .REQ_READY,
		.RSP_VALID, .RSP_DATA, .LOCATION_BITS, .CHIP_ON_N, .STORE_N, .IN_BIT, .OUT_BIT);
	asrp_sram_model asrp_sram_model_inst (.LOCATION_BITS, .CHIP_ON_N, .STORE_N, .IN_BIT, .OUT_BIT);
	initial forever #50 CLOCK = ~CLOCK;
	task automatic cmp(input logic [11:0] got, input logic [11:0] want);
		checks_done++;
		if (got !== want) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask : cmp
	// one request; a changed address is offered while busy
	task automatic op(input logic w, input logic [11:0] a, input logic d, input logic want);
		int n;
		REQ_VALID = 1'h1;
		REQ_WRITE = w;
		REQ_ADDR = a;
		REQ_DATA = d;
		n = 0;
		while (REQ_READY !== 1'h1 && n < 20) begin
			@(posedge CLOCK) #1;
			n++;
		end
		cmp(REQ_READY, 1'h1);
		@(posedge CLOCK) #1;
		REQ_ADDR = ~a;
		cmp(LOCATION_BITS, a);
		cmp(CHIP_ON_N, 1'h0);
		n = 0;
		while (RSP_VALID !== 1'h1 && n < 20) begin
			@(posedge CLOCK) #1;
			n++;
		end
		REQ_VALID = 1'h0;
		cmp(12'(n), w ? 12'(1 + ASRP_WR_CYC) : 12'(ASRP_ACC_CYC));
		cmp(CHIP_ON_N, 1'h1);
		if (!w) cmp(RSP_DATA, want);
		// let one edge pass so the next request never re-raises valid in this step
		@(posedge CLOCK) #1;
	endtask : op
	task automatic t_reset;
		cmp(CHIP_ON_N, 1'h1);
		cmp(STORE_N, 1'h1);
		cmp(REQ_READY, 1'h1);
		$display("test reset done");
	endtask : t_reset
	// corner cells, back to back
	task automatic t_edges;
		op(1'h1, 12'hFFF, 1'h1, 1'h0);
		op(1'h1, 12'h000, 1'h0, 1'h0);
		op(1'h0, 12'hFFF, 1'h0, 1'h1);
		op(1'h0, 12'h000, 1'h1, 1'h0);
		$display("test edges done");
	endtask : t_edges
	// flip one cell, cell at the inverted address kept
	task automatic t_overwrite;
		op(1'h1, 12'hA5A, 1'h0, 1'h0);
		op(1'h1, 12'h5A5, 1'h1, 1'h0);
		op(1'h0, 12'hA5A, 1'h1, 1'h0);
		op(1'h1, 12'hA5A, 1'h1, 1'h0);
		op(1'h0, 12'hA5A, 1'h0, 1'h1);
		op(1'h0, 12'h5A5, 1'h0, 1'h1);
		$display("test overwrite done");
	endtask : t_overwrite
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	// watchdog
	initial begin
		#100000;
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge CLOCK);
		#1;
		RST = 1'h0;
		t_reset();
		t_edges();
		t_overwrite();
		finish_test();
	end
endmodule : asrp_ctrl_tb_top
